// ---- src/mps_pkg.sv ----
package mps_pkg;

    // Core clock rate and derived timing.
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned BLINK_MS = 50;
    localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned BLINK_W = 21;

    // Register indices; the byte address is four times the index.
    localparam logic [13:0] IDX_LED_CFG = 14'h0460;
    localparam logic [13:0] IDX_PIN_A = 14'h0462;
    localparam logic [13:0] IDX_PIN_B = 14'h0463;
    localparam logic [13:0] IDX_STATUS = 14'h0470;
    localparam logic [13:0] IDX_MASK = 14'h0471;
    localparam logic [13:0] IDX_PIN_STATE = 14'h0472;

    // Field positions of the select and LED mode fields.
    localparam int unsigned SEL0_LSB = 0;
    localparam int unsigned SEL1_LSB = 8;
    localparam int unsigned SEL2_LSB = 0;
    localparam int unsigned LED0_LSB = 0;
    localparam int unsigned LED1_LSB = 4;
    localparam int unsigned LED2_LSB = 8;

    // Reset values.
    localparam logic [15:0] LED_CFG_RST = 16'h0010;
    localparam logic [15:0] PIN_A_RST = 16'h0000;
    localparam logic [15:0] PIN_B_RST = 16'h0001;
    localparam logic [3:0] MASK_RST = 4'h0;

    // Pin select codes.
    localparam logic [2:0] SEL_LED = 3'h0;
    localparam logic [2:0] SEL_CLK = 3'h1;
    localparam logic [2:0] SEL_WAKE = 3'h2;
    localparam logic [2:0] SEL_UV = 3'h3;
    localparam logic [2:0] SEL_SFD_TX = 3'h2;
    localparam logic [2:0] SEL_SFD_RX = 3'h3;
    localparam logic [2:0] SEL_LOW = 3'h6;
    localparam logic [2:0] SEL_HIGH = 3'h7;

    // LED mode codes.
    localparam logic [3:0] LED_LINK = 4'h0;
    localparam logic [3:0] LED_LINK_ACT = 4'h1;
    localparam logic [3:0] LED_ACT = 4'h2;
    localparam logic [3:0] LED_OFF = 4'h3;
    localparam logic [3:0] LED_ON = 4'h4;

    // Status bit positions.
    localparam int unsigned ST_WAKE = 0;
    localparam int unsigned ST_UV = 1;
    localparam int unsigned ST_TX_SFD = 2;
    localparam int unsigned ST_RX_SFD = 3;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } mps_tap_e;

    typedef struct packed {
        logic [15:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } mps_av_req_s;

    typedef struct packed {
        logic [BLINK_W-1:0] cnt;
        logic busy;
        logic dark;
        logic pend;
    } mps_blink_s;

    typedef struct packed {
        logic tck_q;
        mps_tap_e st;
        logic in_reset;
        logic [2:0] hi_cnt;
    } mps_tap_s;

    typedef struct packed {
        logic [15:0] led_cfg;
        logic [15:0] pin_a;
        logic [15:0] pin_b;
        logic [3:0] status;
        logic [3:0] mask;
        logic waitreq;
        logic [31:0] rdata;
        logic strap;
        logic strap_done;
        logic [2:0] pins;
        logic [2:0] pins_oe_n;
        logic rxd3;
        logic txclk;
        logic txclk_oe_n;
        logic irq;
    } mps_top_s;

endpackage

// ---- src/mps_blink.sv ----
`timescale 1ns/1ns
module mps_blink #(
    parameter int unsigned BLINK_CYCLES = mps_pkg::BLINK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Activity in, blink phase out.
    input wire logic activity,
    output logic busy,
    output logic dark
);

    mps_pkg::mps_blink_s state_reg;
    mps_pkg::mps_blink_s state_next;

    // Toggles the dark phase once per period while activity keeps arriving.
    always_comb begin
        state_next = state_reg;
        if (activity) begin
            state_next.pend = 1'b1;
            state_next.busy = 1'b1;
        end
        if (state_reg.busy) begin
            if (state_reg.cnt == mps_pkg::BLINK_W'(BLINK_CYCLES - 1)) begin
                state_next.cnt = '0;
                state_next.dark = ~state_reg.dark;
                if (state_reg.dark && !state_reg.pend && !activity) begin
                    state_next.busy = 1'b0;
                    state_next.dark = 1'b0;
                end
                if (state_reg.dark) begin
                    state_next.pend = activity;
                end
            end else begin
                state_next.cnt = state_reg.cnt + 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy = state_reg.busy;
    assign dark = state_reg.dark;

endmodule // mps_blink

// ---- src/mps_tap.sv ----
`timescale 1ns/1ns
module mps_tap (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Test port pins, sampled as levels.
    input wire logic tck,
    input wire logic tms,
    // Controller state.
    output mps_pkg::mps_tap_e tap_state,
    output logic tap_in_reset
);

    mps_pkg::mps_tap_s state_reg;
    mps_pkg::mps_tap_s state_next;
    logic tck_rise;

    // Advances the sixteen-state controller on each rising test clock.
    always_comb begin
        state_next = state_reg;
        tck_rise = tck && !state_reg.tck_q;
        state_next.tck_q = tck;
        if (tck_rise) begin
            state_next.hi_cnt = tms ? ((state_reg.hi_cnt == 3'h7) ? 3'h7
                                : state_reg.hi_cnt + 3'h1) : 3'h0;
            unique case (state_reg.st) // RQ1
                mps_pkg::TAP_RESET: state_next.st = tms ? mps_pkg::TAP_RESET : mps_pkg::TAP_IDLE;
                mps_pkg::TAP_IDLE: state_next.st = tms ? mps_pkg::TAP_SEL_DR : mps_pkg::TAP_IDLE;
                mps_pkg::TAP_SEL_DR: state_next.st = tms ? mps_pkg::TAP_SEL_IR
                                                         : mps_pkg::TAP_CAP_DR;
                mps_pkg::TAP_CAP_DR: state_next.st = tms ? mps_pkg::TAP_EXIT1_DR
                                                         : mps_pkg::TAP_SHIFT_DR;
                mps_pkg::TAP_SHIFT_DR: state_next.st = tms ? mps_pkg::TAP_EXIT1_DR
                                                           : mps_pkg::TAP_SHIFT_DR;
                mps_pkg::TAP_EXIT1_DR: state_next.st = tms ? mps_pkg::TAP_UPD_DR
                                                           : mps_pkg::TAP_PAUSE_DR;
                mps_pkg::TAP_PAUSE_DR: state_next.st = tms ? mps_pkg::TAP_EXIT2_DR
                                                           : mps_pkg::TAP_PAUSE_DR;
                mps_pkg::TAP_EXIT2_DR: state_next.st = tms ? mps_pkg::TAP_UPD_DR
                                                           : mps_pkg::TAP_SHIFT_DR;
                mps_pkg::TAP_UPD_DR: state_next.st = tms ? mps_pkg::TAP_SEL_DR : mps_pkg::TAP_IDLE;
                mps_pkg::TAP_SEL_IR: state_next.st = tms ? mps_pkg::TAP_RESET
                                                         : mps_pkg::TAP_CAP_IR;
                mps_pkg::TAP_CAP_IR: state_next.st = tms ? mps_pkg::TAP_EXIT1_IR
                                                         : mps_pkg::TAP_SHIFT_IR;
                mps_pkg::TAP_SHIFT_IR: state_next.st = tms ? mps_pkg::TAP_EXIT1_IR
                                                           : mps_pkg::TAP_SHIFT_IR;
                mps_pkg::TAP_EXIT1_IR: state_next.st = tms ? mps_pkg::TAP_UPD_IR
                                                           : mps_pkg::TAP_PAUSE_IR;
                mps_pkg::TAP_PAUSE_IR: state_next.st = tms ? mps_pkg::TAP_EXIT2_IR
                                                           : mps_pkg::TAP_PAUSE_IR;
                mps_pkg::TAP_EXIT2_IR: state_next.st = tms ? mps_pkg::TAP_UPD_IR
                                                           : mps_pkg::TAP_SHIFT_IR;
                mps_pkg::TAP_UPD_IR: state_next.st = tms ? mps_pkg::TAP_SEL_DR : mps_pkg::TAP_IDLE;
            endcase
        end
        state_next.in_reset = (state_next.st == mps_pkg::TAP_RESET);
    end

    // State register; the edge detector starts at the pulled-up test clock's idle level.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= '{tck_q: 1'b1, st: mps_pkg::TAP_RESET, in_reset: 1'b1, hi_cnt: 3'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign tap_state = state_reg.st;
    assign tap_in_reset = state_reg.in_reset;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_tap_five_high: assert property ( // RQ1
        state_reg.hi_cnt >= 3'h5 |-> state_reg.st == mps_pkg::TAP_RESET)
        else $error("TAP not in reset after five TMS-high clocks.");
    a_tap_no_edge: assert property ( // RQ1
        !(tck && !state_reg.tck_q) |=> $stable(state_reg.st))
        else $error("TAP state moved without a test clock rise.");
    c_tap_shift_dr: cover property (state_reg.st == mps_pkg::TAP_SHIFT_DR);

endmodule // mps_tap

// ---- src/mps_top.sv ----
// What this block does
// [RQ1] A sixteen-state test port controller is stepped by test mode select.
// [RQ2] The tester resets the test port holding test mode select high for clocks.
// [RQ3] Pin functions come from two pin control registers at adjacent addresses.
// [RQ4] Select code zero drives the pin as an LED chosen by LED configuration.
// [RQ5] Select code one drives a clock output on any of the three pins.
// [RQ6] Code two on the second pin outputs the wake-packet interrupt.
// [RQ7] Code three on the second pin outputs the undervoltage interrupt.
// [RQ8] Pin functions exist for transmit and receive start-of-frame indications.
// [RQ9] Second pin: code six drives low, seven drives high; four, five reserved.
// [RQ10] A strap puts the 50 MHz reference clock on receive bit three.
// [RQ11] Transmit clock pin is an input only in RGMII mode, else driven.
// [RQ12] First LED shows link; second LED shows link and blinks on activity.
// [RQ13] The third pin carries the 25 MHz reference clock by default.
// [RQ14] Reset restores default selections; reserved codes drive a constant low.
`timescale 1ns/1ns
module mps_top #(
    parameter int unsigned BLINK_CYCLES = mps_pkg::BLINK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave.
    input mps_pkg::mps_av_req_s av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // Internal sources of the pin functions.
    input wire logic link_up,
    input wire logic activity,
    input wire logic ref_clk_lvl,
    input wire logic rmii_ref_lvl,
    input wire logic wake_packet_irq,
    input wire logic undervoltage_irq,
    input wire logic tx_sfd,
    input wire logic rx_sfd,
    input wire logic rx_data3,
    input wire logic tx_clk_lvl,
    // Mode and strap levels.
    input wire logic rgmii_mode,
    input wire logic rmii_ref_strap,
    // Test port pins.
    input wire logic tck,
    input wire logic tms,
    // Multipurpose pins and driven clock pins.
    output logic multipin_zero,
    output logic multipin_one,
    output logic multipin_two,
    output logic [2:0] multipin_oe_n,
    output logic receive_bit_three,
    output logic tx_clk_out,
    output logic tx_clk_oe_n,
    // Interrupt and test port status.
    output logic irq,
    output mps_pkg::mps_tap_e tap_state,
    output logic tap_in_reset
);

    mps_pkg::mps_top_s state_reg;
    mps_pkg::mps_top_s state_next;
    logic blink_busy;
    logic blink_dark;
    logic [13:0] idx;
    logic [2:0] sel [3];
    logic [3:0] led_mode [3];
    logic [2:0] led_lvl;
    logic [3:0] events;
    logic commit;
    logic live;

    // Activity blinker for the LED outputs.
    mps_blink #(.BLINK_CYCLES(BLINK_CYCLES)) u_blink (
        .clk_sys(clk_sys),
        .rst(rst),
        .activity(activity),
        .busy(blink_busy),
        .dark(blink_dark)
    );

    // Test port controller.
    mps_tap u_tap (
        .clk_sys(clk_sys),
        .rst(rst),
        .tck(tck),
        .tms(tms),
        .tap_state(tap_state),
        .tap_in_reset(tap_in_reset)
    );

    // Applies a write to a 16-bit register under the byte enables.
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        wr16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Field extraction from the control registers.
    always_comb begin
        sel[0] = state_reg.pin_a[mps_pkg::SEL0_LSB +: 3]; // RQ3
        sel[1] = state_reg.pin_a[mps_pkg::SEL1_LSB +: 3]; // RQ3
        sel[2] = state_reg.pin_b[mps_pkg::SEL2_LSB +: 3]; // RQ3
        led_mode[0] = state_reg.led_cfg[mps_pkg::LED0_LSB +: 4];
        led_mode[1] = state_reg.led_cfg[mps_pkg::LED1_LSB +: 4];
        led_mode[2] = state_reg.led_cfg[mps_pkg::LED2_LSB +: 4];
    end

    // LED level per pin from its configured indication.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            unique case (led_mode[i]) // RQ12
                mps_pkg::LED_LINK: led_lvl[i] = link_up;
                mps_pkg::LED_LINK_ACT: led_lvl[i] = link_up && !blink_dark;
                mps_pkg::LED_ACT: led_lvl[i] = blink_busy && !blink_dark;
                mps_pkg::LED_ON: led_lvl[i] = 1'b1;
                default: led_lvl[i] = 1'b0;
            endcase
        end
    end

    // Events that set the sticky status bits.
    always_comb begin
        events = '0;
        events[mps_pkg::ST_WAKE] = wake_packet_irq;
        events[mps_pkg::ST_UV] = undervoltage_irq;
        events[mps_pkg::ST_TX_SFD] = tx_sfd;
        events[mps_pkg::ST_RX_SFD] = rx_sfd;
    end

    // Next state: bus slave, status, strap capture and pin drivers.
    always_comb begin
        state_next = state_reg;
        idx = av_req.address[15:2];
        commit = !state_reg.waitreq && (av_req.read || av_req.write);
        // A request is answered one cycle after it is seen, and taken at the next edge.
        if (state_reg.waitreq && (av_req.read || av_req.write)) begin
            state_next.waitreq = 1'b0;
            state_next.rdata = '0;
            if (av_req.read) begin
                unique case (idx)
                    mps_pkg::IDX_LED_CFG: state_next.rdata[15:0] = state_reg.led_cfg;
                    mps_pkg::IDX_PIN_A: state_next.rdata[15:0] = state_reg.pin_a;
                    mps_pkg::IDX_PIN_B: state_next.rdata[15:0] = state_reg.pin_b;
                    mps_pkg::IDX_STATUS: state_next.rdata[3:0] = state_reg.status;
                    mps_pkg::IDX_MASK: state_next.rdata[3:0] = state_reg.mask;
                    mps_pkg::IDX_PIN_STATE: state_next.rdata[3:0] = {state_reg.strap,
                                                                     state_reg.pins};
                    default: state_next.rdata = '0;
                endcase
            end
        end else begin
            state_next.waitreq = 1'b1;
        end
        // Writes take effect at the edge where waitrequest is seen low.
        if (commit && av_req.write) begin
            unique case (idx)
                mps_pkg::IDX_LED_CFG: state_next.led_cfg = wr16(state_reg.led_cfg,
                                                                av_req.writedata,
                                                                av_req.byteenable);
                mps_pkg::IDX_PIN_A: state_next.pin_a = wr16(state_reg.pin_a, av_req.writedata,
                                                            av_req.byteenable); // RQ3
                mps_pkg::IDX_PIN_B: state_next.pin_b = wr16(state_reg.pin_b, av_req.writedata,
                                                            av_req.byteenable); // RQ3
                mps_pkg::IDX_MASK: if (av_req.byteenable[0]) begin
                    state_next.mask = av_req.writedata[3:0];
                end
                default: state_next.mask = state_reg.mask;
            endcase
        end
        // Reading status clears only the bits it returned; a new event wins.
        state_next.status = state_reg.status;
        if (commit && av_req.read && idx == mps_pkg::IDX_STATUS) begin
            state_next.status = state_reg.status & ~state_reg.rdata[3:0];
        end
        state_next.status = state_next.status | events;
        state_next.irq = |(state_next.status & state_next.mask);
        // The strap is caught once, on the first edge after reset release.
        if (!state_reg.strap_done) begin
            state_next.strap = rmii_ref_strap;
            state_next.strap_done = 1'b1;
        end
        state_next.rxd3 = (state_reg.strap_done && state_reg.strap) ? rmii_ref_lvl
                          : rx_data3; // RQ10
        state_next.txclk = tx_clk_lvl;
        state_next.txclk_oe_n = rgmii_mode; // RQ11
        state_next.pins_oe_n = 3'h0;
        // Pin multiplexer; unlisted and reserved codes drive a constant low.
        for (int i = 0; i < 3; i++) begin
            state_next.pins[i] = 1'b0; // RQ14
            if (sel[i] == mps_pkg::SEL_LED) begin
                state_next.pins[i] = led_lvl[i]; // RQ4
            end else if (sel[i] == mps_pkg::SEL_CLK) begin
                state_next.pins[i] = ref_clk_lvl; // RQ5
            end else if (i == 1) begin
                unique case (sel[i])
                    mps_pkg::SEL_WAKE: state_next.pins[i] = wake_packet_irq; // RQ6
                    mps_pkg::SEL_UV: state_next.pins[i] = undervoltage_irq; // RQ7
                    mps_pkg::SEL_HIGH: state_next.pins[i] = 1'b1; // RQ9
                    default: state_next.pins[i] = 1'b0; // RQ9
                endcase
            end else if (sel[i] == mps_pkg::SEL_SFD_TX) begin
                state_next.pins[i] = tx_sfd; // RQ8
            end else if (sel[i] == mps_pkg::SEL_SFD_RX) begin
                state_next.pins[i] = rx_sfd; // RQ8
            end
        end
    end

    // State register; pins float during reset and defaults return.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.led_cfg <= mps_pkg::LED_CFG_RST; // RQ12
            state_reg.pin_a <= mps_pkg::PIN_A_RST; // RQ14
            state_reg.pin_b <= mps_pkg::PIN_B_RST; // RQ13
            state_reg.mask <= mps_pkg::MASK_RST;
            state_reg.waitreq <= 1'b1;
            state_reg.pins_oe_n <= 3'h7;
            state_reg.txclk_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register.
    assign av_readdata = state_reg.rdata;
    assign av_waitrequest = state_reg.waitreq;
    assign multipin_zero = state_reg.pins[0];
    assign multipin_one = state_reg.pins[1];
    assign multipin_two = state_reg.pins[2];
    assign multipin_oe_n = state_reg.pins_oe_n;
    assign receive_bit_three = state_reg.rxd3;
    assign tx_clk_out = state_reg.txclk;
    assign tx_clk_oe_n = state_reg.txclk_oe_n;
    assign irq = state_reg.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // High once the pins have left their reset level.
    assign live = (state_reg.pins_oe_n == 3'h0);

    // Bus answer, register writes and pin drive.
    a_wait_one_cycle: assert property ( // RQ3
        !av_waitrequest |=> av_waitrequest)
        else $error("Waitrequest low for more than one cycle.");
    a_write_lands: assert property ( // RQ3
        !av_waitrequest && av_req.write && idx == mps_pkg::IDX_PIN_A && &av_req.byteenable
        |=> state_reg.pin_a == $past(av_req.writedata[15:0]))
        else $error("Pin control write did not land.");
    a_oe_driven: assert property ( // RQ4
        !$past(rst) |-> multipin_oe_n == 3'h0)
        else $error("Multipurpose pins not driven after reset.");

    // Second pin functions.
    a_pin_low: assert property ( // RQ9
        sel[1] == mps_pkg::SEL_LOW |=> !multipin_one)
        else $error("Second pin not low for code six.");
    a_pin_high: assert property ( // RQ9
        sel[1] == mps_pkg::SEL_HIGH |=> multipin_one)
        else $error("Second pin not high for code seven.");
    a_pin_wake: assert property ( // RQ6
        sel[1] == mps_pkg::SEL_WAKE |=> multipin_one == $past(wake_packet_irq))
        else $error("Second pin does not follow wake interrupt.");
    a_pin_uv: assert property ( // RQ7
        sel[1] == mps_pkg::SEL_UV |=> multipin_one == $past(undervoltage_irq))
        else $error("Second pin does not follow undervoltage.");
    a_reserved_low: assert property ( // RQ14
        sel[1] inside {3'h4, 3'h5} |=> !multipin_one)
        else $error("Reserved code does not drive low.");

    // First and third pin functions.
    a_clk_out: assert property ( // RQ5
        live && sel[2] == mps_pkg::SEL_CLK |=> multipin_two == $past(ref_clk_lvl))
        else $error("Third pin does not carry the clock.");
    a_led_link: assert property ( // RQ4
        live && sel[0] == mps_pkg::SEL_LED && led_mode[0] == mps_pkg::LED_LINK
        |=> multipin_zero == $past(link_up))
        else $error("First LED does not show link.");
    a_sfd_tx: assert property ( // RQ8
        sel[0] == mps_pkg::SEL_SFD_TX |=> multipin_zero == $past(tx_sfd))
        else $error("First pin does not show transmit SFD.");

    // Receive bit three and transmit clock direction.
    a_rmii_ref: assert property ( // RQ10
        state_reg.strap_done && state_reg.strap |=> receive_bit_three == $past(rmii_ref_lvl))
        else $error("Receive bit three lacks reference clock.");
    a_rx_data: assert property ( // RQ10
        state_reg.strap_done && !state_reg.strap |=> receive_bit_three == $past(rx_data3))
        else $error("Receive bit three lacks receive data.");
    a_txclk_dir: assert property ( // RQ11
        live |=> tx_clk_oe_n == $past(rgmii_mode))
        else $error("Transmit clock direction wrong.");

    // Interrupt level.
    a_irq_level: assert property (
        irq == |(state_reg.status & state_reg.mask))
        else $error("Interrupt level does not match status and mask.");

    // Main scenarios.
    c_status_read: cover property (!av_waitrequest && av_req.read && idx == mps_pkg::IDX_STATUS);
    c_wake_pin: cover property (sel[1] == mps_pkg::SEL_WAKE ##1 multipin_one);
    c_rmii_strap: cover property (state_reg.strap_done && state_reg.strap);
    c_irq_high: cover property (irq);

endmodule // mps_top

// ---- test/mps_clk_load.sv ----
`timescale 1ns/1ns
module mps_clk_load (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Pin seen by a clock consumer on the board.
    input wire logic pin,
    output int rises
);
    logic last;
    // Counts the rising levels of the pin, as a clocked consumer would see them.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last <= 1'b0;
            rises <= 0;
        end else begin
            last <= pin;
            rises <= rises + int'(pin & ~last);
        end
    end
endmodule // mps_clk_load

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
    logic clk_sys = 0, rst = 1, link_up = 1, activity = 0, ref_clk_lvl = 0, rmii_ref_lvl = 1;
    logic wake = 0, uv = 0, tx_sfd = 0, rx_sfd = 0, rx_data3 = 0, tx_clk_lvl = 0;
    logic rgmii_mode = 0, strap = 1, tck = 0, tms = 1, m0, m1, m2, rb3, txo, txoe, irq, tin;
    logic [2:0] oe_n;
    logic [31:0] av_readdata, rd_q;
    logic av_waitrequest;
    logic [7:0] exp1 = 8'h85;
    mps_pkg::mps_av_req_s av_req = '0;
    mps_pkg::mps_tap_e tap_state;
    int n_fail = 0, cmp_count = 0, rises, lows = 0;
    mps_top #(.BLINK_CYCLES(4)) uut (.clk_sys(clk_sys), .rst(rst), .av_req(av_req),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .link_up(link_up),
        .activity(activity), .ref_clk_lvl(ref_clk_lvl), .rmii_ref_lvl(rmii_ref_lvl),
        .wake_packet_irq(wake), .undervoltage_irq(uv), .tx_sfd(tx_sfd), .rx_sfd(rx_sfd),
        .rx_data3(rx_data3), .tx_clk_lvl(tx_clk_lvl), .rgmii_mode(rgmii_mode),
        .rmii_ref_strap(strap), .tck(tck), .tms(tms), .multipin_zero(m0), .multipin_one(m1),
        .multipin_two(m2), .multipin_oe_n(oe_n), .receive_bit_three(rb3), .tx_clk_out(txo),
        .tx_clk_oe_n(txoe), .irq(irq), .tap_state(tap_state), .tap_in_reset(tin));
    mps_clk_load load (.clk_sys(clk_sys), .rst(rst), .pin(m2), .rises(rises));
    // Free-running core clock.
    always #20 clk_sys = ~clk_sys;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // One bus transfer, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int j;
        @(posedge clk_sys);
        av_req <= '{address: a, read: !w, write: w, byteenable: 4'hf, writedata: d};
        for (j = 0; j < 20; j++) begin
            @(posedge clk_sys);
            if (av_waitrequest === 1'b0) break;
        end
        rd_q = av_readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        if (j == 20) begin
            n_fail++;
            test_done();
        end
    endtask
    task automatic tap_step(input logic m);
        tms <= m;
        tck <= 1'b0;
        cyc(3);
        tck <= 1'b1;
        cyc(4);
    endtask
    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(2);
        chk("multipin_oe_n", 32'h0, {29'h0, oe_n});
        bus(0, 16'h1180, 32'h0); chk("led_cfg", 32'h10, rd_q);
        bus(0, 16'h1188, 32'h0); chk("pin_a", 32'h0, rd_q);
        bus(0, 16'h118c, 32'h0); chk("pin_b", 32'h1, rd_q);
        bus(0, 16'h0000, 32'h0); chk("unmapped", 32'h0, rd_q);
        $display("test reset done");
        // The default clock pin follows the reference level toggled here.
        repeat (4) begin
            ref_clk_lvl <= ~ref_clk_lvl;
            cyc(3);
        end
        chk("clock rises", 32'h2, rises);
        chk("receive_bit_three", 32'h1, {31'h0, rb3});
        $display("test clocks done");
        bus(1, 16'h11c4, 32'h1);
        tx_sfd <= 1'b1;
        cyc(2);
        tx_sfd <= 1'b0;
        cyc(3);
        chk("irq masked", 32'h0, {31'h0, irq});
        wake <= 1'b1;
        cyc(3);
        chk("irq", 32'h1, {31'h0, irq});
        wake <= 1'b0;
        bus(0, 16'h11c0, 32'h0); chk("status", 32'h5, rd_q);
        cyc(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test interrupt done");
        wake <= 1'b1;
        // Every select code of the second pin against a fixed source pattern.
        for (int c = 0; c < 8; c++) begin
            bus(1, 16'h1188, {21'h0, c[2:0], 8'h00});
            cyc(3);
            chk("multipin_one", {31'h0, exp1[c]}, {31'h0, m1});
        end
        tx_sfd <= 1'b1;
        bus(1, 16'h1188, 32'h2); cyc(3); chk("pin0 tx", 32'h1, {31'h0, m0});
        bus(1, 16'h1188, 32'h3); cyc(3); chk("pin0 rx", 32'h0, {31'h0, m0});
        // One activity pulse darkens the second LED for a while, then it is lit again.
        activity <= 1'b1;
        cyc(1);
        activity <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            cyc(1);
            if (m1 === 1'b0) lows++;
        end
        chk("blink dark", 32'h1, {31'h0, lows > 0});
        chk("blink lit", 32'h1, {31'h0, m1});
        $display("test select done");
        rgmii_mode <= 1'b1;
        tx_clk_lvl <= 1'b1;
        cyc(3);
        chk("tx_clk_oe_n", 32'h1, {31'h0, txoe});
        rgmii_mode <= 1'b0;
        cyc(3);
        chk("tx_clk_oe_n", 32'h0, {31'h0, txoe});
        chk("tx_clk_out", 32'h1, {31'h0, txo});
        $display("test tx clock done");
        tap_step(0); tap_step(1); tap_step(0); tap_step(0);
        chk("tap_state", 32'(mps_pkg::TAP_SHIFT_DR), 32'(tap_state));
        repeat (5) tap_step(1);
        chk("tap_in_reset", 32'h1, {31'h0, tin});
        $display("test tap done");
        // A second reset with the strap low gives receive bit three back to receive data.
        strap <= 1'b0;
        rmii_ref_lvl <= 1'b0;
        rx_data3 <= 1'b1;
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(3);
        chk("receive_bit_three", 32'h1, {31'h0, rb3});
        bus(0, 16'h1188, 32'h0); chk("pin_a", 32'h0, rd_q);
        $display("test second reset done");
        test_done();
    end
endmodule // tb
